/* hdl/tsc_top.sv */
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`include "tsc_regs.svh"
// Operation
// - Up count: flag set on roll to zero
// - Center mode: flag set stepping down from modulo
// - Flag clears by read-while-set then write zero
// - New overflow restarts the clearing sequence
// - Writing one to flag changes nothing
// - Interrupt request while enabled and flag set
// - Select clear: up count, per-channel modes
// - Select set: up/down, all channels center PWM
// - Two-bit field disables or picks clock source
// - External and fixed clocks synchronized to bus
// - Three-bit field picks one of eight divisors
// - Prescaler follows source sync and selection
// - Settings shared by all channels
// - Second timer capture input from pin five
// - Second timer compare output drives pin four
// - Second timer disabled: pins are plain port
// - Each timer has own external clock pin
// - Inputs synchronized; external clock max bus/4
module tsc_top #(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic ext_timer_clock_one_i,
    input wire logic ext_timer_clock_two_i,
    input wire logic fixed_alt_clock_i,
    input wire logic timer_select_two_i,
    input wire logic [1:0] channel_mode_bits_i,
    input wire logic compare_level_i,
    input wire logic port_pin_five_i,
    input wire logic port_pin_four_gpio_i,
    output logic port_pin_four_o,
    output logic second_timer_capture_in_o,
    output logic timer_tick_o,
    output logic center_aligned_pwm_o,
    output logic [1:0] channel_mode_eff_o,
    output logic [CNT_W-1:0] count_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    tsc_pkg::tsc_state_t st_ff;
    tsc_pkg::tsc_state_t nxt_st;
    logic rst_n_sync;
    logic [1:0] rst_sync_ff; // Kept apart: it runs on the raw reset, not its own copy
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;

    assign rst_n_sync = rst_sync_ff[1];

    // Combinational helpers
    logic src_tick;
    logic tick;
    logic ovf_event;
    logic ext_sel_sync;
    logic ext_sel_prev;
    logic [6:0] ps_mask;
    logic timer_on;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Source select, prescaler, counter, flag and register bus
    always_comb begin
        nxt_st = st_ff;
        nxt_rdata = 16'h0000;
        // Two-flop synchronizers on both external clock pins, the fixed clock and pin five
        nxt_st.ext_one_sync = {st_ff.ext_one_sync[0], ext_timer_clock_one_i};
        nxt_st.ext_two_sync = {st_ff.ext_two_sync[0], ext_timer_clock_two_i};
        nxt_st.fix_sync = {st_ff.fix_sync[0], fixed_alt_clock_i};
        nxt_st.cap_sync = {st_ff.cap_sync[0], port_pin_five_i};
        nxt_st.ext_one_prev = st_ff.ext_one_sync[1];
        nxt_st.ext_two_prev = st_ff.ext_two_sync[1];
        nxt_st.fix_prev = st_ff.fix_sync[1];
        // Each instance takes its own external clock pin
        ext_sel_sync = timer_select_two_i ? st_ff.ext_two_sync[1]
                                          : st_ff.ext_one_sync[1];
        ext_sel_prev = timer_select_two_i ? st_ff.ext_two_prev : st_ff.ext_one_prev;
        timer_on = (st_ff.ctrl.clock_source_select != `TSC_CSS_OFF);
        // Source selection; rising edges of synchronized clocks
        case (st_ff.ctrl.clock_source_select)
            `TSC_CSS_BUS: src_tick = 1'b1;
            `TSC_CSS_FIX: src_tick = st_ff.fix_sync[1] & ~st_ff.fix_prev;
            `TSC_CSS_EXT: src_tick = ext_sel_sync & ~ext_sel_prev;
            default: src_tick = 1'b0;
        endcase
        // Prescaler after selection, divide by 2^n
        ps_mask = 7'(({7'h00, 1'b1} << st_ff.ctrl.prescale_select) - 8'h01);
        tick = 1'b0;
        if (src_tick) begin
            if ((st_ff.prescale_cnt & ps_mask) == ps_mask) begin
                nxt_st.prescale_cnt = 7'h00;
                tick = 1'b1;
            end else begin
                nxt_st.prescale_cnt = st_ff.prescale_cnt + 7'h01;
            end
        end
        // Counter: up, or up/down in center mode
        ovf_event = 1'b0;
        if (!timer_on) begin
            nxt_st.prescale_cnt = 7'h00;
        end
        if (tick) begin
            if (!st_ff.ctrl.center_align_select) begin
                nxt_st.count_down = 1'b0;
                if (st_ff.count >= st_ff.modulo) begin
                    nxt_st.count = 16'h0000;
                    ovf_event = 1'b1;
                end else begin
                    nxt_st.count = st_ff.count + 16'h0001;
                end
            end else if (st_ff.count_down) begin
                if (st_ff.count == 16'h0000) begin
                    nxt_st.count_down = 1'b0;
                    nxt_st.count = 16'h0001;
                end else begin
                    nxt_st.count = st_ff.count - 16'h0001;
                end
            end else begin
                if (st_ff.count >= st_ff.modulo) begin
                    nxt_st.count_down = 1'b1;
                    nxt_st.count = st_ff.count - 16'h0001;
                    ovf_event = 1'b1;
                end else begin
                    nxt_st.count = st_ff.count + 16'h0001;
                end
            end
        end
        // Register reads: data returned one cycle later
        if (rd_i) begin
            case (addr_i)
                `TSC_ADDR_CTRL: nxt_rdata = {8'h00, st_ff.ctrl};
                `TSC_ADDR_MOD: nxt_rdata = st_ff.modulo;
                `TSC_ADDR_CNT: nxt_rdata = st_ff.count;
                default: nxt_rdata = 16'h0000;
            endcase
            // Reading control while flag set arms the clear
            if (addr_i == `TSC_ADDR_CTRL && st_ff.ctrl.overflow_flag) begin
                nxt_st.clr_state = tsc_pkg::TSC_CLR_ARMED;
            end
        end
        // Register writes
        if (wr_i) begin
            case (addr_i)
                `TSC_ADDR_CTRL: begin
                    nxt_st.ctrl.overflow_irq_enable = wdata_i[`TSC_OIE_BIT];
                    nxt_st.ctrl.center_align_select = wdata_i[`TSC_CAS_BIT];
                    nxt_st.ctrl.clock_source_select = wdata_i[`TSC_CSS_HI:`TSC_CSS_LO];
                    nxt_st.ctrl.prescale_select = wdata_i[`TSC_PS_HI:`TSC_PS_LO];
                    // Zero clears only once armed; one has no effect
                    if (!wdata_i[`TSC_OVF_BIT]
                        && st_ff.clr_state == tsc_pkg::TSC_CLR_ARMED) begin
                        nxt_st.ctrl.overflow_flag = 1'b0;
                    end
                    nxt_st.clr_state = tsc_pkg::TSC_CLR_IDLE;
                end
                `TSC_ADDR_MOD: nxt_st.modulo = wdata_i;
                `TSC_ADDR_CNT: begin
                    nxt_st.count = 16'h0000;
                    nxt_st.count_down = 1'b0;
                    nxt_st.prescale_cnt = 7'h00;
                end
                default: ;
            endcase
        end
        // New overflow wins and restarts the clearing sequence
        if (ovf_event) begin
            nxt_st.ctrl.overflow_flag = 1'b1;
            nxt_st.clr_state = tsc_pkg::TSC_CLR_IDLE;
        end
        // Capture input sampled from pin five
        nxt_st.capture_level = st_ff.cap_sync[1];
        nxt_st.rd_data = 8'h00;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset synchronizer flops
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    // Main state, cleared by the synchronized reset
    always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            st_ff.ext_one_sync <= 2'h0;
            st_ff.ext_two_sync <= 2'h0;
            st_ff.fix_sync <= 2'h0;
            st_ff.cap_sync <= 2'h0;
            st_ff.ext_one_prev <= 1'b0;
            st_ff.ext_two_prev <= 1'b0;
            st_ff.fix_prev <= 1'b0;
            st_ff.ctrl <= `TSC_CTRL_RST;
            st_ff.clr_state <= tsc_pkg::TSC_CLR_IDLE;
            st_ff.modulo <= `TSC_MOD_RST;
            st_ff.count <= 16'h0000;
            st_ff.count_down <= 1'b0;
            st_ff.prescale_cnt <= 7'h00;
            st_ff.rd_data <= 8'h00;
            st_ff.capture_level <= 1'b0;
            rdata_ff <= 16'h0000;
        end else begin
            st_ff.ext_one_sync <= nxt_st.ext_one_sync;
            st_ff.ext_two_sync <= nxt_st.ext_two_sync;
            st_ff.fix_sync <= nxt_st.fix_sync;
            st_ff.cap_sync <= nxt_st.cap_sync;
            st_ff.ext_one_prev <= nxt_st.ext_one_prev;
            st_ff.ext_two_prev <= nxt_st.ext_two_prev;
            st_ff.fix_prev <= nxt_st.fix_prev;
            st_ff.ctrl <= nxt_st.ctrl;
            st_ff.clr_state <= nxt_st.clr_state;
            st_ff.modulo <= nxt_st.modulo;
            st_ff.count <= nxt_st.count;
            st_ff.count_down <= nxt_st.count_down;
            st_ff.prescale_cnt <= nxt_st.prescale_cnt;
            st_ff.rd_data <= nxt_st.rd_data;
            st_ff.capture_level <= nxt_st.capture_level;
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Shared mode drives all channels of the instance
    assign center_aligned_pwm_o = st_ff.ctrl.center_align_select;
    assign channel_mode_eff_o = st_ff.ctrl.center_align_select ? 2'h2
                                : channel_mode_bits_i;
    assign irq_o = st_ff.ctrl.overflow_irq_enable & st_ff.ctrl.overflow_flag;
    assign rdata_o = rdata_ff;
    assign count_o = CNT_W'(st_ff.count);
    assign timer_tick_o = tick;
    assign second_timer_capture_in_o = timer_on & st_ff.capture_level;
    // Pin four: compare output when enabled in compare mode, else port
    assign port_pin_four_o = (timer_on && channel_mode_bits_i != 2'h0)
                             ? compare_level_i : port_pin_four_gpio_i;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_up_ovf;
        @(posedge sys_clk_i) disable iff (!rst_n_sync)
        (tick && !st_ff.ctrl.center_align_select && st_ff.count >= st_ff.modulo)
        |=> (st_ff.count == 16'h0000 && st_ff.ctrl.overflow_flag);
    endproperty
    a_up_ovf: assert property (p_up_ovf) else $error("flag not set on roll");

    property p_ctr_ovf;
        @(posedge sys_clk_i) disable iff (!rst_n_sync)
        (tick && st_ff.ctrl.center_align_select && !st_ff.count_down
         && st_ff.count >= st_ff.modulo) |=> (st_ff.count_down && st_ff.ctrl.overflow_flag);
    endproperty
    a_ctr_ovf: assert property (p_ctr_ovf) else $error("center flag missing");

    property p_clr_needs_read;
        @(posedge sys_clk_i) disable iff (!rst_n_sync)
        $fell(st_ff.ctrl.overflow_flag) |-> $past(st_ff.clr_state == tsc_pkg::TSC_CLR_ARMED)
        && $past(wr_i);
    endproperty
    a_clr_needs_read: assert property (p_clr_needs_read) else $error("bad clear");

    property p_ovf_wins;
        @(posedge sys_clk_i) disable iff (!rst_n_sync)
        ovf_event |=> (st_ff.ctrl.overflow_flag && st_ff.clr_state == tsc_pkg::TSC_CLR_IDLE);
    endproperty
    a_ovf_wins: assert property (p_ovf_wins) else $error("overflow lost");

    property p_wr_one;
        @(posedge sys_clk_i) disable iff (!rst_n_sync)
        (wr_i && addr_i == `TSC_ADDR_CTRL && wdata_i[`TSC_OVF_BIT] && st_ff.ctrl.overflow_flag)
        |=> st_ff.ctrl.overflow_flag;
    endproperty
    a_wr_one: assert property (p_wr_one) else $error("write one cleared flag");

    property p_irq;
        @(posedge sys_clk_i) disable iff (!rst_n_sync)
        irq_o == (st_ff.ctrl.overflow_flag && st_ff.ctrl.overflow_irq_enable);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    property p_stop;
        @(posedge sys_clk_i) disable iff (!rst_n_sync)
        (st_ff.ctrl.clock_source_select == `TSC_CSS_OFF && !(wr_i && addr_i == `TSC_ADDR_CNT))
        |=> $stable(st_ff.count);
    endproperty
    a_stop: assert property (p_stop) else $error("counter ran while off");

    property p_div2;
        @(posedge sys_clk_i) disable iff (!rst_n_sync)
        (tick && st_ff.ctrl.clock_source_select == `TSC_CSS_BUS
         && st_ff.ctrl.prescale_select == 3'h1 && !wr_i) |=> !tick;
    endproperty
    a_div2: assert property (p_div2) else $error("divide by two wrong");

endmodule

/* inc/tsc_pkg.sv */
package tsc_pkg;

    typedef enum logic [1:0] {
        TSC_CLR_IDLE = 2'b00,
        TSC_CLR_ARMED = 2'b01
    } tsc_clr_t;

    typedef struct packed {
        logic overflow_flag;
        logic overflow_irq_enable;
        logic center_align_select;
        logic [1:0] clock_source_select;
        logic [2:0] prescale_select;
    } tsc_ctrl_t;

    typedef struct packed {
        logic [1:0] ext_one_sync;
        logic [1:0] ext_two_sync;
        logic [1:0] fix_sync;
        logic [1:0] cap_sync;
        logic ext_one_prev;
        logic ext_two_prev;
        logic fix_prev;
        tsc_ctrl_t ctrl;
        tsc_clr_t clr_state;
        logic [15:0] modulo;
        logic [15:0] count;
        logic count_down;
        logic [6:0] prescale_cnt;
        logic [7:0] rd_data;
        logic capture_level;
    } tsc_state_t;

endpackage

/* inc/tsc_regs.svh */
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH

// Register offsets (byte addresses)
`define TSC_ADDR_CTRL 8'h00
`define TSC_ADDR_MOD 8'h04
`define TSC_ADDR_CNT 8'h08

// Status and control field positions
`define TSC_OVF_BIT 7
`define TSC_OIE_BIT 6
`define TSC_CAS_BIT 5
`define TSC_CSS_HI 4
`define TSC_CSS_LO 3
`define TSC_PS_HI 2
`define TSC_PS_LO 0

// Reset values
`define TSC_CTRL_RST 8'h00
`define TSC_MOD_RST 16'hFFFF

// Clock source codes
`define TSC_CSS_OFF 2'h0
`define TSC_CSS_BUS 2'h1
`define TSC_CSS_FIX 2'h2
`define TSC_CSS_EXT 2'h3

`endif

/* sim/tb.sv */
`timescale 1ns/100ps
`include "tsc_regs.svh"
module tb;
    logic sys_clk_i, rst_n_i, wr_i, rd_i, rd_d, sel_two, cmp_lvl, pin_five, gpio_four;
    logic [7:0] addr_i;
    logic [15:0] wdata_i, rdata_o, count_o;
    logic [1:0] mode_bits, mode_eff;
    logic ext_one, ext_two, fix_clk, pin_four, cap_in, tick, center_aligned_pwm, irq;
    logic [31:0] r;
    logic [15:0] exp_q[$];
    int fails, cmp_count;

    tsc_top #(.CNT_W(16)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .ext_timer_clock_one_i(ext_one), .ext_timer_clock_two_i(ext_two),
        .fixed_alt_clock_i(fix_clk), .timer_select_two_i(sel_two),
        .channel_mode_bits_i(mode_bits), .compare_level_i(cmp_lvl),
        .port_pin_five_i(pin_five), .port_pin_four_gpio_i(gpio_four),
        .port_pin_four_o(pin_four), .second_timer_capture_in_o(cap_in),
        .timer_tick_o(tick), .center_aligned_pwm_o(center_aligned_pwm), .channel_mode_eff_o(mode_eff),
        .count_o(count_o), .irq_o(irq));
    tsc_far_side far (.ext_one_o(ext_one), .ext_two_o(ext_two), .fix_o(fix_clk));

    // Bus clock, 25 ns period
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    // Comparison and closing
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Bus cycles: one-cycle strobes, expected read data queued
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
    endtask

    // Counts prescaled steps over 256 bus cycles, one step of slack for phase
    task automatic ticks(input int n_exp, input string name);
        int n;
        bit ok;
        n = 0;
        repeat (256) begin
            @(posedge sys_clk_i);
            #1;
            if (tick === 1'b1) n++;
        end
        ok = (n_exp == 0) ? (n == 0) : (n >= n_exp - 1 && n <= n_exp + 1);
        check(name, ok ? n_exp[15:0] : n[15:0], n_exp[15:0]);
    endtask

    // Read monitor: takes the oldest note when read data are due
    always @(posedge sys_clk_i) begin
        if (rd_d === 1'b1) begin
            check("rdata", rdata_o, exp_q.pop_front());
        end
        rd_d <= rd_i;
    end

    // Watchdog
    initial begin
        #(25 * 20000);
        fails++;
        wrap_up();
    end

    // Main sequence
    initial begin
        {rst_n_i, wr_i, rd_i, rd_d, sel_two, cmp_lvl, pin_five, gpio_four} = 8'h00;
        addr_i = 8'h00;
        wdata_i = 16'h0000;
        mode_bits = 2'h0;
        void'($urandom(50564));
        repeat (16) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        rd(`TSC_ADDR_CTRL, 16'h0000);
        rd(`TSC_ADDR_MOD, `TSC_MOD_RST);
        wr(8'h0C, 16'h1234);
        rd(8'h0C, 16'h0000);
        // Pin routing and channel modes, timer off and on
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            gpio_four <= r[0];
            cmp_lvl <= r[1];
            pin_five <= r[2];
            mode_bits <= i[1:0];
            wr(`TSC_ADDR_CTRL, i[2] ? 16'h0008 : 16'h0000);
            repeat (5) @(posedge sys_clk_i);
            #1;
            check("pin_four", {15'h0, pin_four}, {15'h0, (i[2] && i[1:0] != 0) ? r[1] : r[0]});
            check("capture_in", {15'h0, cap_in}, {15'h0, i[2] & r[2]});
            check("mode_eff", {14'h0, mode_eff}, {14'h0, i[1:0]});
        end
        // Prescale ratios on the bus clock
        for (int i = 0; i < 8; i++) begin
            wr(`TSC_ADDR_CTRL, {8'h00, 3'h0, `TSC_CSS_BUS, i[2:0]});
            wr(`TSC_ADDR_CNT, 16'h0000);
            ticks(256 >> i, "bus_ticks");
        end
        wr(`TSC_ADDR_CTRL, 16'h0000);
        ticks(0, "off_ticks");
        wr(`TSC_ADDR_CTRL, {8'h00, 3'h0, `TSC_CSS_EXT, 3'h0});
        wr(`TSC_ADDR_CNT, 16'h0000);
        ticks(32, "ext_one_ticks");
        sel_two <= 1'b1;
        wr(`TSC_ADDR_CNT, 16'h0000);
        ticks(21, "ext_two_ticks");
        wr(`TSC_ADDR_CTRL, {8'h00, 3'h0, `TSC_CSS_FIX, 3'h1});
        wr(`TSC_ADDR_CNT, 16'h0000);
        ticks(8, "fix_ticks");
        // Overflow flag and clearing handshake
        wr(`TSC_ADDR_CTRL, 16'h0000);
        wr(`TSC_ADDR_MOD, 16'h0003);
        wr(`TSC_ADDR_CNT, 16'h0000);
        wr(`TSC_ADDR_CTRL, 16'h0008);
        repeat (10) @(posedge sys_clk_i);
        wr(`TSC_ADDR_CTRL, 16'h0000);
        rd(`TSC_ADDR_CTRL, 16'h0080);
        wr(`TSC_ADDR_CTRL, 16'h00C0);
        rd(`TSC_ADDR_CTRL, 16'h00C0);
        #1;
        check("irq_set", {15'h0, irq}, 16'h0001);
        wr(`TSC_ADDR_CTRL, 16'h0040);
        rd(`TSC_ADDR_CTRL, 16'h0040);
        #1;
        check("irq_clr", {15'h0, irq}, 16'h0000);
        wr(`TSC_ADDR_CTRL, 16'h0080);
        rd(`TSC_ADDR_CTRL, 16'h0000);
        // Overflows keep landing during the clearing sequence
        wr(`TSC_ADDR_MOD, 16'h0001);
        wr(`TSC_ADDR_CTRL, 16'h0008);
        repeat (4) @(posedge sys_clk_i);
        rd(`TSC_ADDR_CTRL, 16'h0088);
        wr(`TSC_ADDR_CTRL, 16'h0008);
        rd(`TSC_ADDR_CTRL, 16'h0088);
        // Center-aligned counting
        wr(`TSC_ADDR_CTRL, 16'h0000);
        rd(`TSC_ADDR_CTRL, 16'h0080);
        wr(`TSC_ADDR_CTRL, 16'h0000);
        wr(`TSC_ADDR_MOD, 16'h0003);
        wr(`TSC_ADDR_CNT, 16'h0000);
        rd(`TSC_ADDR_CTRL, 16'h0000);
        wr(`TSC_ADDR_CTRL, 16'h0028);
        r = 32'h0;
        for (int i = 0; i < 16; i++) begin
            wdata_i <= count_o;
            @(posedge sys_clk_i);
            #1;
            if (count_o > r[15:0]) r[15:0] = count_o;
            if (count_o < wdata_i) r[16] = 1'b1;
        end
        check("center_max", r[15:0], 16'h0003);
        check("center_down", {15'h0, r[16]}, 16'h0001);
        check("center_eff", {13'h0, center_aligned_pwm, mode_eff}, 16'h0006);
        rd(`TSC_ADDR_CTRL, 16'h00A8);
        repeat (4) @(posedge sys_clk_i);
        wrap_up();
    end
endmodule

/* sim/tsc_far_side.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// Far-side clock sources
// ------------------------------------------------------------
module tsc_far_side (
    output logic ext_one_o,
    output logic ext_two_o,
    output logic fix_o
);
    // First timer clock: 200 ns period, well under a quarter of the bus rate
    initial begin
        ext_one_o = 1'b0;
        #7;
        forever #100 ext_one_o = ~ext_one_o;
    end

    // Second timer clock: 300 ns period, phase unrelated to the bus clock
    initial begin
        ext_two_o = 1'b0;
        #11;
        forever #150 ext_two_o = ~ext_two_o;
    end

    // Fixed alternate clock: 400 ns period
    initial begin
        fix_o = 1'b0;
        #3;
        forever #200 fix_o = ~fix_o;
    end
endmodule
